// ---- design/fgt_pkg.sv ----
package fgt_pkg;

	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned STROBE_NS = 1000;
	localparam int unsigned STROBE_CYCLES =
		(STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_FRAMES = 8'h08;
	localparam logic [7:0] OFF_LINELEN = 8'h0C;
	localparam logic [7:0] OFF_LINES = 8'h10;
	localparam logic [7:0] OFF_ROI_X = 8'h14;
	localparam logic [7:0] OFF_ROI_Y = 8'h18;
	localparam logic [7:0] OFF_GPO = 8'h1C;
	localparam logic [7:0] OFF_CCSEL = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFF_EXPOSE = 8'h2C;
	localparam logic [7:0] OFF_LUT_ADDR = 8'h30;
	localparam logic [7:0] OFF_LUT_DATA = 8'h34;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_CONT = 1;
	localparam int CTRL_LSCAN = 2;
	localparam int CTRL_HWTRIG = 3;
	localparam int CTRL_FALL = 4;
	localparam int CTRL_STOP = 5;
	localparam int CTRL_FMT = 8;
	localparam int CTRL_LUTEN = 10;

	// Status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_LSCAN = 1;
	localparam int STAT_GPI = 8;
	localparam int STAT_TRIG = 12;

	// Interrupt status fields
	localparam int IRQ_GPI = 0;
	localparam int IRQ_DONE = 4;
	localparam int IRQ_MISSED = 5;
	localparam int IRQ_W = 6;

	// Field positions of window and camera control registers
	localparam int ROI_HI = 16;
	localparam int CCSEL_VAL = 8;

	// Reset values
	localparam logic [15:0] FRAMES_RST = 16'h0001;
	localparam logic [14:0] LINELEN_RST = 15'h0400;
	localparam logic [12:0] LINES_RST = 13'h0400;
	localparam logic [15:0] EXPOSE_RST = 16'h0014;

	// Size limits
	localparam logic [14:0] LINE_MIN = 15'h0010;
	localparam logic [14:0] LINE_MAX_AREA = 15'h1000;
	localparam logic [14:0] LINE_MAX_LS = 15'h4000;
	localparam logic [12:0] LINES_MIN = 13'h0001;
	localparam logic [12:0] LINES_MAX = 13'h1000;

	// Pixel formats
	typedef enum logic [1:0] {
		FGT_FMT_MONO8,
		FGT_FMT_DUAL8,
		FGT_FMT_RGB,
		FGT_FMT_DEEP
	} fgt_fmt_t;

	// Camera control output roles
	typedef enum logic [1:0] {
		FGT_CC_GP,
		FGT_CC_EXPOSE,
		FGT_CC_INTEGRATE,
		FGT_CC_STROBE
	} fgt_cc_t;

	typedef struct packed {
		logic fval;
		logic lval;
		logic dval;
		logic [23:0] data;
	} fgt_cam_t;

	typedef struct packed {
		logic sof;
		logic sol;
		logic [23:0] data;
	} fgt_pix_t;

endpackage

// ---- design/fgt_sync.sv ----
module fgt_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta;
	logic [W-1:0] q_d;

	// Only the second stage reads the first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
			q_d <= '0;
		end else begin
			meta <= d;
			q <= meta;
			q_d <= q;
		end
	end

	assign rise = q & ~q_d;
	assign fall = ~q & q_d;
endmodule // fgt_sync

// ---- design/fgt_top.sv ----
// What this block does
// - Four digital inputs, each raising an interrupt when its level changes.
// - Four digital outputs whose levels software sets.
// - One trigger input; software picks rising or falling edge.
// - Area scan: trigger edge starts one frame or a programmed series.
// - Line scan: each trigger edge starts capture of one line.
// - Line scan: digital input 0 is the frame trigger.
// - Frame trigger starts a frame of triggered lines; unused in area scan.
// - Area scan: lines of 16 to 4096 pixels, 1 to 4096 lines.
// - Line scan: lines of 16 up to 16384 pixels.
// - Only pixels inside the programmed window reach memory.
// - Four camera controls, each expose, integrate, strobe or plain output.
// - Progressive, single or continuous, soft or hard trigger, async reset.
// - One lookup table for mono 8-bit, dual 8-bit and RGB pixels.
// - Pixels leave in the same packing they arrived in.
//
// The APB interface to the registers and the register addresses were left to the implementer.
module fgt_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [3:0] gpi,
	output logic [3:0] gpo,
	input wire logic trig_in,
	output logic strobe_out,
	output logic [3:0] cam_ctrl,
	input wire logic cam_clk,
	input wire fgt_pkg::fgt_cam_t cam_in,
	output logic pix_valid,
	output fgt_pkg::fgt_pix_t pix_out
);
	localparam int IRQ_W_L = fgt_pkg::IRQ_W;
	localparam logic [4:0] STROBE_LEN = 5'(fgt_pkg::STROBE_CYCLES);

	typedef enum logic [2:0] {
		S_IDLE, S_ARM, S_WAIT_FRM, S_GRAB, S_LS_FRM, S_LS_LINE, S_LS_GRAB
	} fgt_state_t;

	fgt_state_t state;
	logic cont, ls_mode, hw_trig, trig_fall, lut_en;
	fgt_pkg::fgt_fmt_t fmt;
	logic [15:0] frames, frames_left, expose_len, exp_cnt;
	logic [14:0] line_len, rx0, rx1, x, eff_len;
	logic [12:0] lines, ry0, ry1, y;
	logic [7:0] cc_sel;
	logic [3:0] cc_val;
	logic [IRQ_W_L-1:0] irq_stat, irq_mask, irq_rd, irq_set;
	logic [7:0] lut_addr;
	logic [7:0] lut [256];
	logic [4:0] strobe_cnt;
	logic [31:0] rd_val;
	logic hit, wr, rd_acc, start_p, stop_p, ext_edge, go, missed;
	logic lval_d, fval_d, in_line, pe, line_end, frm_rise, frm_end, take;
	logic frame_done, last_line, expose, integrate, strobe;
	logic [3:0] gpi_s, gpi_r, gpi_f;
	logic trig_s, trig_r, trig_f;
	logic [27:0] cam_s, cam_f;
	fgt_pkg::fgt_cam_t cs;

	// Pins and camera lines cross into pclk here
	fgt_sync #(.W(4)) u_gpi_sync (
		.pclk(pclk), .presetn(presetn), .d(gpi),
		.q(gpi_s), .rise(gpi_r), .fall(gpi_f));
	fgt_sync #(.W(1)) u_trig_sync (
		.pclk(pclk), .presetn(presetn), .d(trig_in),
		.q(trig_s), .rise(trig_r), .fall(trig_f));
	fgt_sync #(.W(28)) u_cam_sync (
		.pclk(pclk), .presetn(presetn), .d({cam_clk, cam_in}),
		.q(cam_s), .rise(), .fall(cam_f));

	assign cs = cam_s[26:0];
	// Data taken on the falling pixel clock, mid-way between launches
	assign pe = cam_f[27];

	// APB: zero wait states, read data loaded in the setup cycle
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign start_p = wr && paddr == fgt_pkg::OFF_CTRL &&
		pwdata[fgt_pkg::CTRL_START];
	assign stop_p = wr && paddr == fgt_pkg::OFF_CTRL &&
		pwdata[fgt_pkg::CTRL_STOP];

	always_comb begin
		rd_val = '0;
		hit = 1'b1;
		if (paddr == fgt_pkg::OFF_CTRL) begin
			rd_val[fgt_pkg::CTRL_CONT] = cont;
			rd_val[fgt_pkg::CTRL_LSCAN] = ls_mode;
			rd_val[fgt_pkg::CTRL_HWTRIG] = hw_trig;
			rd_val[fgt_pkg::CTRL_FALL] = trig_fall;
			rd_val[fgt_pkg::CTRL_FMT +: 2] = fmt;
			rd_val[fgt_pkg::CTRL_LUTEN] = lut_en;
		end else if (paddr == fgt_pkg::OFF_STATUS) begin
			rd_val[fgt_pkg::STAT_BUSY] = state != S_IDLE;
			rd_val[fgt_pkg::STAT_LSCAN] = ls_mode;
			rd_val[fgt_pkg::STAT_GPI +: 4] = gpi_s;
			rd_val[fgt_pkg::STAT_TRIG] = trig_s;
		end else if (paddr == fgt_pkg::OFF_FRAMES) begin
			rd_val[15:0] = frames;
		end else if (paddr == fgt_pkg::OFF_LINELEN) begin
			rd_val[14:0] = line_len;
		end else if (paddr == fgt_pkg::OFF_LINES) begin
			rd_val[12:0] = lines;
		end else if (paddr == fgt_pkg::OFF_ROI_X) begin
			rd_val = {1'b0, rx1, 1'b0, rx0};
		end else if (paddr == fgt_pkg::OFF_ROI_Y) begin
			rd_val = {3'h0, ry1, 3'h0, ry0};
		end else if (paddr == fgt_pkg::OFF_GPO) begin
			rd_val[3:0] = gpo;
		end else if (paddr == fgt_pkg::OFF_CCSEL) begin
			rd_val = {20'h0, cc_val, cc_sel};
		end else if (paddr == fgt_pkg::OFF_IRQ_STATUS) begin
			rd_val[IRQ_W_L-1:0] = irq_stat;
		end else if (paddr == fgt_pkg::OFF_IRQ_MASK) begin
			rd_val[IRQ_W_L-1:0] = irq_mask;
		end else if (paddr == fgt_pkg::OFF_EXPOSE) begin
			rd_val[15:0] = expose_len;
		end else if (paddr == fgt_pkg::OFF_LUT_ADDR) begin
			rd_val[7:0] = lut_addr;
		end else if (paddr == fgt_pkg::OFF_LUT_DATA) begin
			rd_val[7:0] = lut[lut_addr];
		end else begin
			hit = 1'b0;
		end
	end

	assign pslverr = psel && penable && !hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= rd_val;
		end
	end

	// Control and window registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cont <= 1'b0;
			ls_mode <= 1'b0;
			hw_trig <= 1'b0;
			trig_fall <= 1'b0;
			lut_en <= 1'b0;
			fmt <= fgt_pkg::FGT_FMT_MONO8;
			frames <= fgt_pkg::FRAMES_RST;
			line_len <= fgt_pkg::LINELEN_RST;
			lines <= fgt_pkg::LINES_RST;
			rx0 <= '0;
			rx1 <= 15'h7FFF;
			ry0 <= '0;
			ry1 <= 13'h1FFF;
			gpo <= '0;
			cc_sel <= '0;
			cc_val <= '0;
			irq_mask <= '0;
			expose_len <= fgt_pkg::EXPOSE_RST;
		end else if (wr) begin
			if (paddr == fgt_pkg::OFF_CTRL) begin
				cont <= pwdata[fgt_pkg::CTRL_CONT];
				ls_mode <= pwdata[fgt_pkg::CTRL_LSCAN];
				hw_trig <= pwdata[fgt_pkg::CTRL_HWTRIG];
				trig_fall <= pwdata[fgt_pkg::CTRL_FALL];
				fmt <= fgt_pkg::fgt_fmt_t'(pwdata[fgt_pkg::CTRL_FMT +: 2]);
				lut_en <= pwdata[fgt_pkg::CTRL_LUTEN];
			end else if (paddr == fgt_pkg::OFF_FRAMES) begin
				frames <= pwdata[15:0];
			end else if (paddr == fgt_pkg::OFF_LINELEN) begin
				line_len <= pwdata[14:0];
			end else if (paddr == fgt_pkg::OFF_LINES) begin
				lines <= pwdata[12:0];
			end else if (paddr == fgt_pkg::OFF_ROI_X) begin
				rx0 <= pwdata[14:0];
				rx1 <= pwdata[fgt_pkg::ROI_HI +: 15];
			end else if (paddr == fgt_pkg::OFF_ROI_Y) begin
				ry0 <= pwdata[12:0];
				ry1 <= pwdata[fgt_pkg::ROI_HI +: 13];
			end else if (paddr == fgt_pkg::OFF_GPO) begin
				gpo <= pwdata[3:0];
			end else if (paddr == fgt_pkg::OFF_CCSEL) begin
				cc_sel <= pwdata[7:0];
				cc_val <= pwdata[fgt_pkg::CCSEL_VAL +: 4];
			end else if (paddr == fgt_pkg::OFF_IRQ_MASK) begin
				irq_mask <= pwdata[IRQ_W_L-1:0];
			end else if (paddr == fgt_pkg::OFF_EXPOSE) begin
				expose_len <= pwdata[15:0];
			end
		end
	end

	// Lookup table, data port auto-increments the index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lut_addr <= '0;
		end else if (wr && paddr == fgt_pkg::OFF_LUT_ADDR) begin
			lut_addr <= pwdata[7:0];
		end else if (psel && penable && paddr == fgt_pkg::OFF_LUT_DATA) begin
			lut_addr <= lut_addr + 8'h01;
		end
	end

	always_ff @(posedge pclk) begin
		if (wr && paddr == fgt_pkg::OFF_LUT_DATA) begin
			lut[lut_addr] <= pwdata[7:0];
		end
	end

	// Sizes clamped to what each mode supports
	always_comb begin
		eff_len = line_len < fgt_pkg::LINE_MIN ? fgt_pkg::LINE_MIN : line_len;
		if (ls_mode && eff_len > fgt_pkg::LINE_MAX_LS) begin
			eff_len = fgt_pkg::LINE_MAX_LS;
		end else if (!ls_mode && eff_len > fgt_pkg::LINE_MAX_AREA) begin
			eff_len = fgt_pkg::LINE_MAX_AREA;
		end
	end

	assign last_line = ls_mode ?
		(y + 13'h0001 >= lines && y + 13'h0001 >= fgt_pkg::LINES_MIN) :
		(y + 13'h0001 >= (lines == 13'h0000 ? fgt_pkg::LINES_MIN :
			(lines > fgt_pkg::LINES_MAX ? fgt_pkg::LINES_MAX : lines)));

	// Trigger selection and state machine
	assign ext_edge = trig_fall ? trig_f : trig_r;
	assign go = hw_trig ? ext_edge : 1'b1;
	assign line_end = pe && lval_d && !cs.lval;
	assign frm_rise = pe && cs.fval && !fval_d;
	assign frm_end = pe && fval_d && !cs.fval;
	assign frame_done = (state == S_GRAB && (frm_end ||
		(line_end && last_line))) ||
		(state == S_LS_GRAB && in_line && line_end && last_line);
	// Triggers that land outside a waiting state are dropped
	assign missed = hw_trig && ext_edge && state != S_IDLE &&
		state != S_ARM && state != S_LS_LINE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			frames_left <= '0;
		end else if (stop_p) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (start_p) begin
						// Mode bit of this very write picks the flow
						state <= pwdata[fgt_pkg::CTRL_LSCAN] ? S_LS_FRM : S_ARM;
					end
				end
				S_ARM: begin
					if (go) begin
						state <= S_WAIT_FRM;
						frames_left <= frames == 16'h0000 ? 16'h0001 : frames;
					end
				end
				S_WAIT_FRM: begin
					if (frm_rise) begin
						state <= S_GRAB;
					end
				end
				S_GRAB: begin
					if (frame_done) begin
						frames_left <= frames_left - 16'h0001;
						if (frames_left > 16'h0001) begin
							state <= S_WAIT_FRM;
						end else begin
							state <= cont ? S_ARM : S_IDLE;
						end
					end
				end
				S_LS_FRM: begin
					if (hw_trig ? gpi_r[0] : 1'b1) begin
						state <= S_LS_LINE;
					end
				end
				S_LS_LINE: begin
					if (go) begin
						state <= S_LS_GRAB;
					end
				end
				S_LS_GRAB: begin
					if (frame_done) begin
						state <= cont ? S_LS_FRM : S_IDLE;
					end else if (in_line && line_end) begin
						state <= S_LS_LINE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Pixel position tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lval_d <= 1'b0;
			fval_d <= 1'b0;
			in_line <= 1'b0;
			x <= '0;
			y <= '0;
		end else begin
			if (pe) begin
				lval_d <= cs.lval;
				fval_d <= cs.fval;
				if (!cs.lval) begin
					x <= '0;
				end else if (cs.dval && x != 15'h7FFF) begin
					x <= x + 15'h0001;
				end
			end
			if (state != S_LS_GRAB) begin
				in_line <= 1'b0;
			end else if (pe && cs.lval && !lval_d) begin
				in_line <= 1'b1;
			end
			if (state == S_WAIT_FRM || state == S_LS_FRM || state == S_IDLE) begin
				y <= '0;
			end else if (line_end && (state == S_GRAB || in_line)) begin
				y <= y + 13'h0001;
			end
		end
	end

	// Window, lookup and output; packing of lanes is kept
	// First pixel of a line arrives before in_line is set
	assign take = pe && cs.lval && cs.dval && x < eff_len &&
		(state == S_GRAB || (state == S_LS_GRAB && (in_line || !lval_d)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_valid <= 1'b0;
			pix_out <= '0;
		end else begin
			pix_valid <= take && x >= rx0 && x <= rx1 &&
				y >= ry0 && y <= ry1;
			if (take) begin
				pix_out.sof <= x == 15'h0000 && y == 13'h0000;
				pix_out.sol <= x == 15'h0000;
				pix_out.data <= cs.data;
				if (lut_en && fmt != fgt_pkg::FGT_FMT_DEEP) begin
					pix_out.data[7:0] <= lut[cs.data[7:0]];
				end
				if (lut_en && fmt != fgt_pkg::FGT_FMT_DEEP &&
					fmt != fgt_pkg::FGT_FMT_MONO8) begin
					pix_out.data[15:8] <= lut[cs.data[15:8]];
				end
				if (lut_en && fmt == fgt_pkg::FGT_FMT_RGB) begin
					pix_out.data[23:16] <= lut[cs.data[23:16]];
				end
			end
		end
	end

	// Expose pulse starts the camera at each accepted trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exp_cnt <= '0;
			strobe_cnt <= '0;
		end else if ((state == S_ARM || state == S_LS_LINE) && go &&
			!stop_p) begin
			exp_cnt <= expose_len;
			strobe_cnt <= STROBE_LEN;
		end else begin
			if (exp_cnt != 16'h0000) begin
				exp_cnt <= exp_cnt - 16'h0001;
			end
			if (strobe_cnt != 5'h00) begin
				strobe_cnt <= strobe_cnt - 5'h01;
			end
		end
	end

	assign expose = exp_cnt != 16'h0000;
	assign strobe = strobe_cnt != 5'h00;
	assign integrate = state == S_GRAB || state == S_LS_GRAB;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cam_ctrl <= '0;
			strobe_out <= 1'b0;
		end else begin
			strobe_out <= strobe;
			for (int i = 0; i < 4; i++) begin
				case (fgt_pkg::fgt_cc_t'(cc_sel[2*i +: 2]))
					fgt_pkg::FGT_CC_EXPOSE: cam_ctrl[i] <= expose;
					fgt_pkg::FGT_CC_INTEGRATE: cam_ctrl[i] <= integrate;
					fgt_pkg::FGT_CC_STROBE: cam_ctrl[i] <= strobe;
					default: cam_ctrl[i] <= cc_val[i];
				endcase
			end
		end
	end

	// Interrupts: read clears only what the read returned, set wins
	assign irq_rd = (rd_acc && paddr == fgt_pkg::OFF_IRQ_STATUS) ?
		prdata[IRQ_W_L-1:0] : '0;
	assign irq_set = {missed, frame_done, gpi_r | gpi_f};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_rd) | irq_set;
			irq <= |(irq_stat & irq_mask);
		end
	end
endmodule // fgt_top

// ---- test/fgt_chk.sv ----
module fgt_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic [3:0] gpo,
	input wire logic strobe_out,
	input wire logic [3:0] cam_ctrl,
	input wire logic cam_clk,
	input wire logic pix_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wr_acc;
	logic cam_q;
	int unsigned st_len;
	int unsigned since_fall;

	assign wr_acc = psel && penable && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_len <= 0;
		end else begin
			st_len <= strobe_out ? st_len + 1 : 0;
		end
	end

	// Saturates so an idle link clock cannot wrap it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cam_q <= 1'h0;
			since_fall <= 99;
		end else begin
			cam_q <= cam_clk;
			if (cam_q && !cam_clk) begin
				since_fall <= 0;
			end else if (since_fall < 99) begin
				since_fall <= since_fall + 1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_gpo_write;
		wr_acc && paddr == fgt_pkg::OFF_GPO |=> gpo == $past(pwdata[3:0]);
	endproperty
	a_gpo_write: assert property (p_gpo_write)
		else $error("gpo misses write");
	property p_gpo_hold;
		!(wr_acc && paddr == fgt_pkg::OFF_GPO) |=> $stable(gpo);
	endproperty
	a_gpo_hold: assert property (p_gpo_hold)
		else $error("gpo moved without write");
	// Register value, then registered pin: two edges after the write
	property p_ccsel_gp;
		wr_acc && paddr == fgt_pkg::OFF_CCSEL && pwdata[7:0] == 8'h00
			|-> ##2 cam_ctrl == $past(pwdata[11:8], 2);
	endproperty
	a_ccsel_gp: assert property (p_ccsel_gp)
		else $error("camera controls miss plain values");
	property p_mask_off;
		wr_acc && paddr == fgt_pkg::OFF_IRQ_MASK && pwdata[5:0] == 6'h00
			|-> ##2 !irq;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("irq high with all masked");
	property p_strobe_len;
		$fell(strobe_out) |-> st_len == fgt_pkg::STROBE_CYCLES;
	endproperty
	a_strobe_len: assert property (p_strobe_len)
		else $error("strobe width wrong");
	property p_pix_pulse;
		pix_valid |=> !pix_valid;
	endproperty
	a_pix_pulse: assert property (p_pix_pulse)
		else $error("pixel strobe too long");
	property p_pix_cause;
		pix_valid |-> since_fall inside {[2:8]};
	endproperty
	a_pix_cause: assert property (p_pix_cause)
		else $error("pixel without link clock fall");
	property p_unmapped;
		psel && penable && paddr > fgt_pkg::OFF_LUT_DATA |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");

	c_strobe: cover property ($fell(strobe_out));
	c_pix: cover property (pix_valid);
	c_irq: cover property ($rose(irq));
endmodule // fgt_chk

// ---- test/fgt_cam_model.sv ----
module fgt_cam_model (
	output logic cam_clk,
	output fgt_pkg::fgt_cam_t cam_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cam_clk = 1'h0;
		cam_in = '0;
	end

	// Clock runs only for frames plus one closing clock that drops fval; two blank clocks lead each line
	task automatic send(input int lines, input int pix);
		#13;
		for (int l = 0; l < lines; l++) begin
			for (int p = 0; p < pix + 2; p++) begin
				#200;
				cam_clk = 1'h1;
				cam_in.fval = 1'h1;
				cam_in.lval = 1'(p >= 2);
				cam_in.dval = 1'(p >= 2);
				// Idle data toggles so stale words never pass as valid
				cam_in.data = (p >= 2) ? {l[11:0], 12'(p - 2)} : ~cam_in.data;
				#200;
				cam_clk = 1'h0;
			end
		end
		#200;
		cam_clk = 1'h1;
		cam_in.fval = 1'h0;
		cam_in.lval = 1'h0;
		cam_in.dval = 1'h0;
		#200;
		cam_clk = 1'h0;
	endtask
endmodule // fgt_cam_model

// ---- test/fgt_top_tb.sv ----
bind fgt_top fgt_chk i_fgt_chk (.pclk, .presetn, .paddr, .psel, .penable,
	.pwrite, .pwdata, .pslverr, .irq, .gpo, .strobe_out, .cam_ctrl,
	.cam_clk, .pix_valid);

module fgt_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [3:0] gpi;
	logic [3:0] gpo;
	logic trig_in;
	logic strobe_out;
	logic [3:0] cam_ctrl;
	logic cam_clk;
	fgt_pkg::fgt_cam_t cam_in;
	logic pix_valid;
	fgt_pkg::fgt_pix_t pix_out;
	logic [31:0] rdata;
	logic rerr;
	logic [23:0] last_pix;
	int errors;
	int tests_run;
	int npix;
	int n;

	fgt_top i_fgt_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .irq, .gpi, .gpo, .trig_in,
		.strobe_out, .cam_ctrl, .cam_clk, .cam_in, .pix_valid, .pix_out);
	fgt_cam_model i_fgt_cam_model (.cam_clk, .cam_in);

	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (pix_valid === 1'h1) begin
			npix <= npix + 1;
			last_pix <= pix_out.data;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		check(rdata, exp);
	endtask

	task automatic wait_irq(input logic e);
		for (int i = 0; i < 20 && irq !== e; i++) @(posedge pclk);
		check({31'h0, irq}, {31'h0, e});
	endtask

	task automatic stop_test;
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#500_000;
		errors++;
		stop_test();
	end

	initial begin
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		gpi = 4'h0;
		trig_in = 1'h0;
		{errors, tests_run, npix} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		rd(fgt_pkg::OFF_FRAMES, 32'h1);
		rd(fgt_pkg::OFF_LINELEN, 32'h400);
		rd(fgt_pkg::OFF_LINES, 32'h400);
		rd(fgt_pkg::OFF_ROI_X, 32'h7FFF_0000);
		rd(fgt_pkg::OFF_ROI_Y, 32'h1FFF_0000);
		rd(fgt_pkg::OFF_EXPOSE, 32'h14);
		rd(8'h40, 32'h0);
		check({31'h0, rerr}, 32'h1);
		for (int v = 5; v < 16; v += 5) begin
			wr(fgt_pkg::OFF_GPO, 32'(v));
			// Write lands at the access edge; look one edge later
			@(posedge pclk);
			check({28'h0, gpo}, 32'(v));
		end
		wr(fgt_pkg::OFF_IRQ_MASK, 32'hF);
		for (int i = 0; i < 4; i++) begin
			gpi[i] <= 1'h1;
			wait_irq(1'h1);
			rd(fgt_pkg::OFF_IRQ_STATUS, 32'h1 << i);
			wait_irq(1'h0);
		end
		apb(1'h0, fgt_pkg::OFF_STATUS, 32'h0);
		check({28'h0, rdata[11:8]}, 32'hF);
		wr(fgt_pkg::OFF_IRQ_MASK, 32'h0);
		gpi <= 4'h6;
		repeat (10) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		rd(fgt_pkg::OFF_IRQ_STATUS, 32'h9);
		wr(fgt_pkg::OFF_CCSEL, 32'hA00);
		repeat (2) @(posedge pclk);
		check({28'h0, cam_ctrl}, 32'hA);
		wr(fgt_pkg::OFF_CCSEL, 32'h1E4);
		repeat (2) @(posedge pclk);
		check({31'h0, cam_ctrl[0]}, 32'h1);
		wr(fgt_pkg::OFF_LUT_ADDR, 32'h5);
		wr(fgt_pkg::OFF_LUT_DATA, 32'h5A);
		rd(fgt_pkg::OFF_LUT_ADDR, 32'h6);
		wr(fgt_pkg::OFF_LUT_ADDR, 32'h5);
		rd(fgt_pkg::OFF_LUT_DATA, 32'h5A);
		wr(fgt_pkg::OFF_EXPOSE, 32'h6);
		wr(fgt_pkg::OFF_LINELEN, 32'h10);
		wr(fgt_pkg::OFF_LINES, 32'h2);
		wr(fgt_pkg::OFF_ROI_X, 32'h0005_0002);
		wr(fgt_pkg::OFF_ROI_Y, 32'h0001_0000);
		wr(fgt_pkg::OFF_IRQ_MASK, 32'h30);
		wr(fgt_pkg::OFF_CTRL, 32'h9);
		trig_in <= 1'h1;
		n = 0;
		for (int i = 0; i < 20 && cam_ctrl[1] !== 1'h1; i++) @(posedge pclk);
		while (cam_ctrl[1] === 1'h1 && n < 99) begin
			@(posedge pclk);
			n++;
		end
		check(32'(n), 32'h6);
		trig_in <= 1'h0;
		repeat (4) @(posedge pclk);
		// Second edge lands while the frame is still pending
		trig_in <= 1'h1;
		repeat (6) @(posedge pclk);
		apb(1'h0, fgt_pkg::OFF_STATUS, 32'h0);
		check({31'h0, rdata[0]}, 32'h1);
		i_fgt_cam_model.send(2, 16);
		repeat (20) @(posedge pclk);
		check(32'(npix), 32'h8);
		check({8'h0, last_pix}, 32'h1005);
		check({31'h0, irq}, 32'h1);
		rd(fgt_pkg::OFF_IRQ_STATUS, 32'h30);
		apb(1'h0, fgt_pkg::OFF_STATUS, 32'h0);
		check({31'h0, rdata[0]}, 32'h0);
		npix = 0;
		wr(fgt_pkg::OFF_LINES, 32'h1);
		// Window from column 0 so a lost first pixel shows
		wr(fgt_pkg::OFF_ROI_X, 32'h0005_0000);
		wr(fgt_pkg::OFF_CTRL, 32'h41D);
		// Falling edge before the frame trigger must be refused
		trig_in <= 1'h0;
		repeat (10) @(posedge pclk);
		gpi <= 4'h7;
		repeat (10) @(posedge pclk);
		trig_in <= 1'h1;
		repeat (6) @(posedge pclk);
		trig_in <= 1'h0;
		repeat (10) @(posedge pclk);
		i_fgt_cam_model.send(1, 16);
		repeat (20) @(posedge pclk);
		check(32'(npix), 32'h6);
		check({8'h0, last_pix}, 32'h5A);
		rd(fgt_pkg::OFF_IRQ_STATUS, 32'h31);
		stop_test();
	end
endmodule // fgt_top_tb
